// [bsc_pkg.sv]
package bsc_pkg;
  localparam int INSN_W = 14;
  localparam int PC_W = 13;
  localparam int DATA_W = 8;
  localparam int FADDR_W = 7;
  localparam int STACK_DEPTH = 8;
  // Opcode match patterns
  localparam logic [3:0] OPC_SKIP_CLR = 4'h6;
  localparam logic [3:0] OPC_SKIP_SET = 4'h7;
  localparam logic [2:0] OPC_CALL = 3'h4;
  localparam logic [6:0] OPC_CLR_FILE = 7'h03;
  localparam logic [13:0] OPC_CLR_ACC = 14'h0103;
  localparam logic [5:0] OPC_INVERT = 6'h09;
  // Field positions
  localparam int BIT_SEL_LSB = 7;
  localparam int DEST_BIT = 7;
  localparam int KADDR_W = 11;
  localparam int LATCH_HI_LSB = 3;
  localparam logic [7:0] ZERO_BYTE = 8'h00;
  localparam logic [12:0] PC_RESET = 13'h0000;
  localparam logic [13:0] NO_OPERATION = 14'h0000;
endpackage

// [bsc_stack.sv]
`timescale 1ns/1ps
module bsc_stack #(
  parameter int WIDTH = 13,
  parameter int DEPTH = 8
) (
  input wire logic ref_clk_i,
  input wire logic rst_i,
  // Push
  input wire logic push_i,
  input wire logic [WIDTH-1:0] push_data_i,
  // Stack top
  output logic [WIDTH-1:0] top_o
);
  initial begin
    if (DEPTH < 2 || WIDTH < 1) begin
      $error("bsc_stack: bad parameters");
    end
  end

  logic [WIDTH-1:0] mem [DEPTH];
  logic [$clog2(DEPTH)-1:0] ptr;

  // Circular stack: overflow overwrites the oldest entry, no error raised
  always_ff @(posedge ref_clk_i) begin
    if (rst_i) begin
      ptr <= '0;
    end else if (push_i) begin
      ptr <= ptr + 1'b1;
    end
  end

  always_ff @(posedge ref_clk_i) begin
    if (push_i) begin
      mem[ptr] <= push_data_i;
    end
  end

  always_ff @(posedge ref_clk_i) begin
    if (rst_i) begin
      top_o <= '0;
    end else if (push_i) begin
      top_o <= push_data_i;
    end
  end
endmodule

// [bsc_core.sv]
// What this block does
// - Skip-if-set tests the selected bit of the file register, skipping on one.
// - A taken skip discards the fetched word and runs a no-operation, two cycles.
// - A call pushes the program counter plus one onto the return stack.
// - A call loads PC 10..0 from the immediate and PC 12..11 from latch bits 4..3.
// - A call is one word, two cycles, and changes no flag.
// - Clear-file writes 00h to the file register and sets zero in one cycle.
// - Clear-accumulator has a fixed encoding, zeroes the accumulator, sets zero.
// - Invert complements the file register, updates zero, and picks destination.
// - With destination zero only the accumulator gets the inverted value.
// - Skip-if-clear skips when the selected bit of the file register is zero.
`timescale 1ns/1ps
module bsc_core #(
  parameter int STACK_DEPTH = bsc_pkg::STACK_DEPTH
) (
  input wire logic ref_clk_i,
  input wire logic rst_i,
  // Instruction fetch
  input wire logic [bsc_pkg::INSN_W-1:0] insn_i,
  input wire logic insn_valid_i,
  input wire logic [bsc_pkg::PC_W-1:0] pc_i,
  input wire logic [bsc_pkg::DATA_W-1:0] upper_program_latch_i,
  // File register read port
  output logic [bsc_pkg::FADDR_W-1:0] file_addr_o,
  input wire logic [bsc_pkg::DATA_W-1:0] file_rdata_i,
  // File register write
  output logic file_we_o,
  output logic [bsc_pkg::FADDR_W-1:0] file_waddr_o,
  output logic [bsc_pkg::DATA_W-1:0] file_wdata_o,
  // Accumulator and zero flag
  output logic [bsc_pkg::DATA_W-1:0] acc_o,
  output logic zero_flag_o,
  // Program flow
  output logic pc_load_o,
  output logic [bsc_pkg::PC_W-1:0] pc_target_o,
  output logic flush_o,
  output logic busy_o,
  output logic [bsc_pkg::PC_W-1:0] stack_top_entry_o
);
  initial begin
    if (STACK_DEPTH < 2) begin
      $error("bsc_core: stack depth too small");
    end
  end

  typedef enum logic [1:0] {
    BSC_EXEC,
    BSC_SKIP_NOP,
    BSC_CALL_2ND
  } bsc_state_t;

  bsc_state_t state;
  bsc_state_t next_state;

  logic executing;
  logic is_skip_set;
  logic is_skip_clr;
  logic is_call;
  logic is_clr_file;
  logic is_clr_acc;
  logic is_invert;
  logic sel_bit;
  logic skip_taken;
  logic [bsc_pkg::DATA_W-1:0] inverted;
  logic invert_to_file;
  logic push;
  logic [bsc_pkg::PC_W-1:0] ret_addr;

  // Fetch slot consumed by a skip or call is not decoded
  assign executing = insn_valid_i && (state == BSC_EXEC);

  assign is_skip_set = executing && (insn_i[13:10] == bsc_pkg::OPC_SKIP_SET);
  assign is_skip_clr = executing && (insn_i[13:10] == bsc_pkg::OPC_SKIP_CLR);
  assign is_call = executing && (insn_i[13:11] == bsc_pkg::OPC_CALL);
  assign is_clr_file = executing && (insn_i[13:7] == bsc_pkg::OPC_CLR_FILE);
  assign is_clr_acc = executing && (insn_i == bsc_pkg::OPC_CLR_ACC);
  assign is_invert = executing && (insn_i[13:8] == bsc_pkg::OPC_INVERT);

  // Read port is combinational toward the file; data comes back same cycle
  assign file_addr_o = insn_i[bsc_pkg::FADDR_W-1:0];
  assign sel_bit = file_rdata_i[insn_i[bsc_pkg::BIT_SEL_LSB +: 3]];

  assign skip_taken = (is_skip_set && sel_bit)
    || (is_skip_clr && !sel_bit);

  assign inverted = ~file_rdata_i;
  assign invert_to_file = is_invert && insn_i[bsc_pkg::DEST_BIT];

  assign ret_addr = pc_i + 1'b1;
  assign push = is_call;

  always_comb begin
    next_state = state;
    case (state)
      BSC_EXEC: begin
        if (skip_taken) begin
          next_state = BSC_SKIP_NOP;
        end else if (is_call) begin
          next_state = BSC_CALL_2ND;
        end
      end
      BSC_SKIP_NOP: begin
        if (insn_valid_i) begin
          next_state = BSC_EXEC;
        end
      end
      BSC_CALL_2ND: begin
        if (insn_valid_i) begin
          next_state = BSC_EXEC;
        end
      end
      default: begin
        next_state = BSC_EXEC;
      end
    endcase
  end

  always_ff @(posedge ref_clk_i) begin
    if (rst_i) begin
      state <= BSC_EXEC;
    end else begin
      state <= next_state;
    end
  end

  // Second cycle of skip/call holds off the fetcher
  assign busy_o = (state != BSC_EXEC);

  always_ff @(posedge ref_clk_i) begin
    if (rst_i) begin
      flush_o <= 1'b0;
    end else begin
      flush_o <= skip_taken || is_call;
    end
  end

  always_ff @(posedge ref_clk_i) begin
    if (rst_i) begin
      pc_load_o <= 1'b0;
      pc_target_o <= bsc_pkg::PC_RESET;
    end else begin
      pc_load_o <= is_call;
      if (is_call) begin
        pc_target_o <= {upper_program_latch_i[bsc_pkg::LATCH_HI_LSB +: 2],
          insn_i[bsc_pkg::KADDR_W-1:0]};
      end
    end
  end

  bsc_stack #(
    .WIDTH(bsc_pkg::PC_W),
    .DEPTH(STACK_DEPTH)
  ) u_stack (
    .ref_clk_i(ref_clk_i),
    .rst_i(rst_i),
    .push_i(push),
    .push_data_i(ret_addr),
    .top_o(stack_top_entry_o)
  );

  always_ff @(posedge ref_clk_i) begin
    if (rst_i) begin
      file_we_o <= 1'b0;
      file_waddr_o <= '0;
      file_wdata_o <= bsc_pkg::ZERO_BYTE;
    end else begin
      file_we_o <= is_clr_file || invert_to_file;
      file_waddr_o <= insn_i[bsc_pkg::FADDR_W-1:0];
      if (is_clr_file) begin
        file_wdata_o <= bsc_pkg::ZERO_BYTE;
      end else if (invert_to_file) begin
        file_wdata_o <= inverted;
      end
    end
  end

  always_ff @(posedge ref_clk_i) begin
    if (rst_i) begin
      acc_o <= bsc_pkg::ZERO_BYTE;
    end else if (is_clr_acc) begin
      acc_o <= bsc_pkg::ZERO_BYTE;
    end else if (is_invert && !insn_i[bsc_pkg::DEST_BIT]) begin
      acc_o <= inverted;
    end
  end

  // Call and skips leave the flag alone
  always_ff @(posedge ref_clk_i) begin
    if (rst_i) begin
      zero_flag_o <= 1'b0;
    end else if (is_clr_file || is_clr_acc) begin
      zero_flag_o <= 1'b1;
    end else if (is_invert) begin
      zero_flag_o <= (inverted == bsc_pkg::ZERO_BYTE);
    end
  end
endmodule

// [bsc_core_chk.sv]
`timescale 1ns/1ps
module bsc_core_chk (
  // Fetch side
  input wire logic ref_clk_i,
  input wire logic rst_i,
  input wire logic [13:0] insn_i,
  input wire logic insn_valid_i,
  input wire logic [12:0] pc_i,
  input wire logic [7:0] upper_program_latch_i,
  input wire logic [7:0] file_rdata_i,
  input wire logic [6:0] file_addr_o,
  // Results
  input wire logic file_we_o,
  input wire logic [6:0] file_waddr_o,
  input wire logic [7:0] file_wdata_o,
  input wire logic [7:0] acc_o,
  input wire logic zero_flag_o,
  input wire logic pc_load_o,
  input wire logic [12:0] pc_target_o,
  input wire logic flush_o,
  input wire logic busy_o,
  input wire logic [12:0] stack_top_entry_o
);
  default clocking @(posedge ref_clk_i);
  endclocking
  default disable iff (rst_i);
  // A word offered while busy is the dropped slot, never a command
  wire tk = insn_valid_i && !busy_o;
  wire tst = tk && insn_i[13:11] == 3'h3;
  wire sk = tst && file_rdata_i[insn_i[9:7]] == insn_i[10];
  wire cl = tk && insn_i[13:11] == 3'h4;
  wire iv = tk && insn_i[13:8] == 6'h09;
  sequence slot2_s;
    flush_o && busy_o && insn_valid_i ##1 !busy_o;
  endsequence
  skip_taken_a: assert property (sk |=> slot2_s)
    else $error("skip lost");
  skip_none_a: assert property (tst && !sk |=> !flush_o && !busy_o)
    else $error("bad skip");
  call_flow_a: assert property (
    cl |=> pc_load_o && $stable(zero_flag_o) ##0 slot2_s)
    else $error("call flow");
  call_target_a: assert property (cl |=> pc_target_o ==
    {$past(upper_program_latch_i[4:3]), $past(insn_i[10:0])})
    else $error("call target");
  call_push_a: assert property (
    cl |=> stack_top_entry_o == $past(pc_i) + 13'h0001)
    else $error("return address");
  clear_file_a: assert property (tk && insn_i[13:7] == 7'h03 |=>
    file_we_o && file_wdata_o == 8'h00 && zero_flag_o &&
    file_waddr_o == $past(insn_i[6:0]))
    else $error("clear file");
  clear_acc_a: assert property (
    tk && insn_i == 14'h0103 |=> acc_o == 8'h00 && zero_flag_o)
    else $error("clear acc");
  invert_acc_a: assert property (iv && !insn_i[7] |=>
    acc_o == ~$past(file_rdata_i) && !file_we_o)
    else $error("invert acc");
  invert_file_a: assert property (iv && insn_i[7] |=>
    file_we_o && file_wdata_o == ~$past(file_rdata_i))
    else $error("invert file");
  read_addr_a: assert property (
    tk |-> file_addr_o == insn_i[6:0])
    else $error("read address");
  invert_zero_a: assert property (
    iv |=> zero_flag_o == (~$past(file_rdata_i) == 8'h00))
    else $error("invert zero");
endmodule
bind bsc_core bsc_core_chk i_chk (.*);

// [tb_top.sv]
`timescale 1ns/1ps
module tb_top;
  logic ref_clk_i = 0, rst_i = 1, insn_valid_i = 0, pend = 0;
  logic [13:0] insn_i = 0;
  logic [12:0] pc_i = 0, pc_target_o, stack_top_entry_o, tgt = 0, top = 0;
  logic [7:0] upper_program_latch_i = 0, file_rdata_i = 0;
  logic [7:0] file_wdata_o, acc_o, acc = 0;
  logic [6:0] file_waddr_o;
  logic file_we_o, zero_flag_o, pc_load_o, flush_o, busy_o, z = 0, ign = 0;
  logic [45:0] q[$];
  logic [45:0] e;
  logic [31:0] r = 32'h88F8;
  int failures = 0, comparisons = 0, cyc = 0;
  // Write data only matters while the strobe is up
  wire [45:0] seen = {flush_o, pc_load_o, pc_target_o, stack_top_entry_o,
    file_we_o, file_we_o ? file_wdata_o : 8'h00, acc_o, zero_flag_o};
  always #5 ref_clk_i = ~ref_clk_i;
  bsc_core i_dut (.*, .file_addr_o());
  function automatic logic [31:0] nx(logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction
  task automatic check(string n, logic [45:0] s, logic [45:0] x);
    comparisons++;
    if (s !== x) begin
      failures++;
      $display("wrong value %s expected %h seen %h", n, x, s);
    end
  endtask
  task automatic wrap_up;
    $display("comparisons %0d failures %0d", comparisons, failures);
    if (failures == 0 && comparisons > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask
  task automatic issue;
    logic [13:0] w;
    logic [7:0] f, wd;
    logic fl, we, ld;
    r = nx(r);
    // All-ones data often, so inverts reach a zero result
    f = r[8] ? 8'hFF : r[31:24];
    case (r[2:0])
      0: w = {3'h3, r[13:3]};
      1: w = {3'h4, r[13:3]};
      2: w = {7'h03, r[9:3]};
      3: w = 14'h0103;
      default: w = {6'h09, r[10:3]};
    endcase
    {fl, we, ld, wd} = '0;
    if (ign) ign = 0;
    else if (w[13:11] == 3'h3) begin
      fl = f[w[9:7]] == w[10];
      ign = fl;
    end else if (w[13:11] == 3'h4) begin
      {fl, ld, ign} = 3'h7;
      tgt = {r[20:19], w[10:0]};
      top = r[31:19] + 13'h0001;
    end else if (w[13:7] == 7'h03) {we, z} = 2'h3;
    else if (w == 14'h0103) {acc, z} = 9'h001;
    else if (w[13:8] == 6'h09) begin
      wd = ~f;
      z = wd == 8'h00;
      if (w[7]) we = 1;
      else acc = wd;
    end
    if (!we) wd = 0;
    q.push_back({fl, ld, tgt, top, we, wd, acc, z});
    insn_i <= w;
    file_rdata_i <= f;
    upper_program_latch_i <= r[23:16];
    pc_i <= r[31:19];
    insn_valid_i <= 1;
  endtask
  always @(posedge ref_clk_i) pend <= insn_valid_i;
  always @(negedge ref_clk_i) begin
    if (pend) begin
      e = q.pop_front();
      check("pc", seen[45:18], e[45:18]);
      check("data", seen[17:0], e[17:0]);
    end
  end
  always @(posedge ref_clk_i) begin
    cyc++;
    if (cyc > 1000) begin
      failures++;
      wrap_up;
    end
  end
  initial begin
    repeat (12) @(posedge ref_clk_i);
    rst_i <= 0;
    @(negedge ref_clk_i);
    check("reset", seen, '0);
    repeat (400) begin
      @(posedge ref_clk_i);
      issue;
    end
    // Fill the dropped slot of a trailing skip or call before going idle
    while (ign) begin
      @(posedge ref_clk_i);
      issue;
    end
    @(posedge ref_clk_i);
    insn_valid_i <= 0;
    repeat (2) @(posedge ref_clk_i);
    wrap_up;
  end
endmodule
